// >>> front_panel_pkg.sv
// constants, types and register map of the front-panel setup menu
package front_panel_pkg;
	// ==========================================================
	// register map (byte addresses) and field positions
	localparam logic [3:0] REG_STATUS       = 4'h0;
	localparam logic [3:0] REG_SETTINGS     = 4'h4;
	localparam logic [3:0] REG_HOLD         = 4'h8;
	localparam int         STAT_SETUP_BIT   = 8;
	localparam int         STAT_SCREEN_LSB  = 12;
	localparam int         STAT_VALUE_LSB   = 16;
	localparam int         SET_SHARED_LSB   = 4;
	localparam int         SET_P2_BIT       = 9;
	localparam int         SET_P3_BIT       = 10;
	localparam int         SET_SLAVE_LSB    = 12;
	// ==========================================================
	// reset values and code ranges
	localparam logic [7:0] ADDRESS_RESET    = 8'h01;
	localparam logic [3:0] RATE_CODE_RESET  = 4'h4;
	localparam logic [3:0] RATE_CODE_MAX    = 4'h9;
	localparam logic [4:0] SHARED_DASH      = 5'h00;
	localparam logic [4:0] SHARED_C2_BASE   = 5'h01;
	localparam logic [4:0] SHARED_C3_BASE   = 5'h0B;
	localparam logic [4:0] SHARED_MAX       = 5'h14;
	localparam logic [4:0] SHARED_RESET     = 5'h05;
	localparam logic [1:0] ITEM_RATE1       = 2'h0;
	localparam logic [1:0] ITEM_SHARED      = 2'h1;
	localparam logic [1:0] ITEM_ERASE       = 2'h2;
	localparam logic [1:0] ITEM_RESET       = 2'h1;
	localparam logic [4:0] MODE_RS232       = 5'h00;
	localparam logic [4:0] MODE_RS485       = 5'h01;
	localparam logic [4:0] MODE_RS232_485   = 5'h02;
	localparam logic [1:0] START_CYCLES     = 2'h3;
	// ==========================================================
	// timing
	localparam int         CLK_KHZ          = 100_000;
	localparam int         MSG_TIME_MS      = 500;
	localparam int         MSG_CYCLES       = MSG_TIME_MS * CLK_KHZ;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		SCR_RUN, SCR_SELECT, SCR_RATE1, SCR_SHARED, SCR_ERASE, SCR_MODE, SCR_CLEARED
	} screen_type;
	typedef struct packed {
		screen_type screen;
		logic [4:0] value;
	} display_type;
	typedef struct packed {
		logic [3:0] port1_code;
		logic [4:0] shared_sel;
	} nv_settings_type;
	typedef struct packed {
		logic [3:0] port1_code;
		logic       port2_slave;
		logic       port3_slave;
		logic [3:0] slave_code;
	} port_config_type;
	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} avalon_req_type;
endpackage

// >>> front_panel_setup_menu.sv
// power-up setup menu: station address, port rates, slave roles and erase
//
// Function
// - address from switches, switch one LSB
// - delivered switch setting gives address one
// - first port defaults 19200, 8N1
// - first two keys held enters setup
// - setup opens on shared-port menu item, index 1
// - up/down step items, OK enters
// - rate codes 0..9 decode, keys step
// - first-port screen shows stored code
// - OK stores, shows mode, returns; reboot applies
// - second/third ports share one screen
// - shared screen opens second port code four
// - chosen code makes port Modbus slave
// - dash makes both ports non-slave
// - third port non-slave, slaves 19200 default
// - erase prompt opens no, keys toggle
// - OK on yes erases, shows complete
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module front_panel_setup_menu #(
	parameter int MSG_CYCLES = front_panel_pkg::MSG_CYCLES
) (
	input  wire logic                            mclk_i,
	input  wire logic                            reset_n_i,
	input  wire logic [7:0]                      address_switch_i,
	input  wire logic                            key_up_i,
	input  wire logic                            step_down_key_i,
	input  wire logic                            key_ok_i,
	input  wire logic                            nv_valid_i,
	input  wire front_panel_pkg::nv_settings_type nv_data_i,
	input  wire front_panel_pkg::avalon_req_type  avs_req_i,
	output logic [31:0]                          avs_readdata_o,
	output logic                                 avs_waitrequest_o,
	output logic [7:0]                           station_address_o,
	output logic                                 setup_mode_o,
	output front_panel_pkg::display_type         display_o,
	output front_panel_pkg::port_config_type     port_config_o,
	output front_panel_pkg::nv_settings_type     nv_data_o,
	output logic                                 nv_write_o,
	output logic                                 erase_app_o
);
	typedef enum {ST_START, ST_RUN, ST_SELECT, ST_RATE1, ST_SHARED, ST_ERASE, ST_MODE,
		ST_CLEARED} state_type;
	// ==========================================================
	// pin synchronisers
	logic [2:0] key_meta;
	logic [2:0] key_sync;
	logic [2:0] key_prev;
	logic [7:0] sw_meta;
	logic [7:0] sw_sync;
	// two flops per pin; press is a rising edge after the second flop
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			key_meta <= 3'h0;
			key_sync <= 3'h0;
			key_prev <= 3'h0;
			sw_meta  <= front_panel_pkg::ADDRESS_RESET;
			sw_sync  <= front_panel_pkg::ADDRESS_RESET;
		end
		else
		begin
			key_meta <= {key_ok_i, step_down_key_i, key_up_i};
			key_sync <= key_meta;
			key_prev <= key_sync;
			sw_meta  <= address_switch_i;
			sw_sync  <= sw_meta;
		end
	end
	wire [2:0] press   = key_sync & ~key_prev;
	wire       up_p    = press[0];
	wire       down_p  = press[1];
	wire       ok_p    = press[2];
	// switch one is bit 0, switch eight bit 7, plain binary
	assign station_address_o = sw_sync;
	// ==========================================================
	// menu state
	state_type                         state;
	state_type                         next_state;
	logic [1:0]                        item;
	logic [1:0]                        next_item;
	logic [3:0]                        code_edit;
	logic [3:0]                        next_code;
	logic [4:0]                        shared_edit;
	logic [4:0]                        next_shared;
	logic                              erase_yes;
	logic                              next_yes;
	logic                              save;
	logic                              erase;
	logic [1:0]                        start_cnt;
	logic [31:0]                       hold_cnt;
	logic [31:0]                       hold_cycles;
	front_panel_pkg::nv_settings_type  stored;
	wire start_done = (start_cnt == front_panel_pkg::START_CYCLES);
	wire both_held  = key_sync[0] & key_sync[1];
	// menu transitions; keys act as one-cycle presses
	always_comb
	begin
		next_state  = state;
		next_item   = item;
		next_code   = code_edit;
		next_shared = shared_edit;
		next_yes    = erase_yes;
		save        = 1'b0;
		erase       = 1'b0;
		case (state)
			ST_START:
			begin
				if (start_done)
				begin
					next_state = both_held ? ST_SELECT : ST_RUN;
					next_item  = front_panel_pkg::ITEM_RESET;
				end
			end
			ST_SELECT:
			begin
				if (up_p)
					next_item = (item == front_panel_pkg::ITEM_RATE1) ?
						front_panel_pkg::ITEM_ERASE : item - 2'h1;
				else if (down_p)
					next_item = (item == front_panel_pkg::ITEM_ERASE) ?
						front_panel_pkg::ITEM_RATE1 : item + 2'h1;
				else if (ok_p)
				begin
					case (item)
						front_panel_pkg::ITEM_RATE1:
						begin
							next_state = ST_RATE1;
							next_code  = stored.port1_code;
						end
						front_panel_pkg::ITEM_SHARED:
						begin
							next_state  = ST_SHARED;
							next_shared = front_panel_pkg::SHARED_RESET;
						end
						default:
						begin
							next_state = ST_ERASE;
							next_yes   = 1'b0;
						end
					endcase
				end
			end
			ST_RATE1:
			begin
				if (up_p)
					next_code = (code_edit == front_panel_pkg::RATE_CODE_MAX) ?
						4'h0 : code_edit + 4'h1;
				else if (down_p)
					next_code = (code_edit == 4'h0) ?
						front_panel_pkg::RATE_CODE_MAX : code_edit - 4'h1;
				else if (ok_p)
				begin
					save       = 1'b1;
					next_state = ST_MODE;
				end
			end
			ST_SHARED:
			begin
				// down walks second-port codes, then third-port codes, then dash
				if (down_p)
					next_shared = (shared_edit == front_panel_pkg::SHARED_MAX) ?
						front_panel_pkg::SHARED_DASH : shared_edit + 5'h01;
				else if (up_p)
					next_shared = (shared_edit == front_panel_pkg::SHARED_DASH) ?
						front_panel_pkg::SHARED_MAX : shared_edit - 5'h01;
				else if (ok_p)
				begin
					save       = 1'b1;
					next_state = ST_MODE;
				end
			end
			ST_ERASE:
			begin
				if (up_p | down_p)
					next_yes = ~erase_yes;
				else if (ok_p)
				begin
					erase      = erase_yes;
					next_state = erase_yes ? ST_CLEARED : ST_SELECT;
				end
			end
			ST_MODE:
				if (hold_cnt == 32'h0)
					next_state = ST_SELECT;
			default:
				next_state = state; // run and cleared wait for reboot
		endcase
	end
	// ==========================================================
	// decode of a stored setting into the port configuration
	function automatic front_panel_pkg::port_config_type decode_config(
		input front_panel_pkg::nv_settings_type s
	);
		front_panel_pkg::port_config_type c;
		c.port1_code  = s.port1_code;
		c.port2_slave = (s.shared_sel >= front_panel_pkg::SHARED_C2_BASE) &&
			(s.shared_sel < front_panel_pkg::SHARED_C3_BASE);
		c.port3_slave = (s.shared_sel >= front_panel_pkg::SHARED_C3_BASE);
		if (s.shared_sel >= front_panel_pkg::SHARED_C3_BASE)
			c.slave_code = 4'(s.shared_sel - front_panel_pkg::SHARED_C3_BASE);
		else if (s.shared_sel >= front_panel_pkg::SHARED_C2_BASE)
			c.slave_code = 4'(s.shared_sel - front_panel_pkg::SHARED_C2_BASE);
		else
			c.slave_code = front_panel_pkg::RATE_CODE_RESET;
		return c;
	endfunction
	wire front_panel_pkg::nv_settings_type boot_set =
		nv_valid_i ? nv_data_i :
		{front_panel_pkg::RATE_CODE_RESET, front_panel_pkg::SHARED_RESET};
	// menu registers
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			state       <= ST_START;
			item        <= front_panel_pkg::ITEM_RESET;
			code_edit   <= front_panel_pkg::RATE_CODE_RESET;
			shared_edit <= front_panel_pkg::SHARED_RESET;
			erase_yes   <= 1'b0;
			start_cnt   <= 2'h0;
			hold_cnt    <= 32'h0;
		end
		else
		begin
			state       <= next_state;
			item        <= next_item;
			code_edit   <= next_code;
			shared_edit <= next_shared;
			erase_yes   <= next_yes;
			if (!start_done)
				start_cnt <= start_cnt + 2'h1;
			if (save)
				hold_cnt <= hold_cycles;
			else if (hold_cnt != 32'h0)
				hold_cnt <= hold_cnt - 32'h1;
		end
	end
	// stored settings and boot-time configuration
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			stored        <= {front_panel_pkg::RATE_CODE_RESET,
				front_panel_pkg::SHARED_RESET};
			port_config_o <= decode_config({front_panel_pkg::RATE_CODE_RESET,
				front_panel_pkg::SHARED_RESET});
			nv_write_o    <= 1'b0;
			erase_app_o   <= 1'b0;
			setup_mode_o  <= 1'b0;
		end
		else
		begin
			nv_write_o  <= save;
			erase_app_o <= erase;
			if (state == ST_START && start_done)
			begin
				stored        <= boot_set;
				port_config_o <= decode_config(boot_set);
				setup_mode_o  <= both_held;
			end
			else if (save && state == ST_RATE1)
				stored.port1_code <= code_edit;
			else if (save)
				stored.shared_sel <= shared_edit;
		end
	end
	assign nv_data_o = stored;
	// ==========================================================
	// display
	// the entry being saved picks the mode from the first mode cycle on
	wire [4:0] mode_sel   = (state == ST_SHARED) ? shared_edit : stored.shared_sel;
	wire [4:0] mode_value = (item == front_panel_pkg::ITEM_RATE1) ? front_panel_pkg::MODE_RS232 :
		(mode_sel >= front_panel_pkg::SHARED_C3_BASE) ?
		front_panel_pkg::MODE_RS232_485 : front_panel_pkg::MODE_RS485;
	// screen and its value, both from flops
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			display_o <= {front_panel_pkg::SCR_RUN, 5'h00};
		else
		begin
			case (next_state)
				ST_SELECT:  display_o <= {front_panel_pkg::SCR_SELECT, 3'h0, next_item};
				ST_RATE1:   display_o <= {front_panel_pkg::SCR_RATE1, 1'b0, next_code};
				ST_SHARED:  display_o <= {front_panel_pkg::SCR_SHARED, next_shared};
				ST_ERASE:   display_o <= {front_panel_pkg::SCR_ERASE, 4'h0, next_yes};
				ST_MODE:    display_o <= {front_panel_pkg::SCR_MODE, mode_value};
				ST_CLEARED: display_o <= {front_panel_pkg::SCR_CLEARED, 5'h00};
				default:    display_o <= {front_panel_pkg::SCR_RUN, 5'h00};
			endcase
		end
	end
	// ==========================================================
	// avalon-mm slave, one wait state per access
	logic ack;
	wire  access  = avs_req_i.read | avs_req_i.write;
	wire  hit_st  = (avs_req_i.address == front_panel_pkg::REG_STATUS);
	wire  hit_set = (avs_req_i.address == front_panel_pkg::REG_SETTINGS);
	wire  hit_hld = (avs_req_i.address == front_panel_pkg::REG_HOLD);
	wire [31:0] status_word = (32'(station_address_o)) |
		(32'(setup_mode_o) << front_panel_pkg::STAT_SETUP_BIT) |
		(32'(display_o.screen) << front_panel_pkg::STAT_SCREEN_LSB) |
		(32'(display_o.value) << front_panel_pkg::STAT_VALUE_LSB);
	wire [31:0] settings_word = (32'(stored.port1_code)) |
		(32'(stored.shared_sel) << front_panel_pkg::SET_SHARED_LSB) |
		(32'(port_config_o.port2_slave) << front_panel_pkg::SET_P2_BIT) |
		(32'(port_config_o.port3_slave) << front_panel_pkg::SET_P3_BIT) |
		(32'(port_config_o.slave_code) << front_panel_pkg::SET_SLAVE_LSB);
	wire [31:0] read_word = hit_st ? status_word : hit_set ? settings_word :
		hit_hld ? hold_cycles : 32'h0;
	assign avs_waitrequest_o = access & ~ack;
	// read data loads before the answer cycle; writes land on it
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			ack            <= 1'b0;
			avs_readdata_o <= 32'h0;
			hold_cycles    <= 32'(MSG_CYCLES);
		end
		else
		begin
			ack <= access & ~ack;
			if (avs_req_i.read & ~ack)
				avs_readdata_o <= read_word;
			if (avs_req_i.write & ack & hit_hld)
				hold_cycles <= avs_req_i.writedata;
		end
	end
endmodule

// >>> front_panel_setup_menu_unused.sv
// spare source file of the setup menu: holds no logic or declarations

// >>> front_panel_setup_menu_assertions.sv
// concurrent checks on the ports of the front-panel setup menu
`timescale 1ns/1ps
module front_panel_setup_menu_assertions #(
	parameter int MSG_CYCLES = front_panel_pkg::MSG_CYCLES
) (
	input wire logic                             mclk_i,
	input wire logic                             reset_n_i,
	input wire logic [7:0]                       address_switch_i,
	input wire front_panel_pkg::avalon_req_type  avs_req_i,
	input wire logic                             avs_waitrequest_o,
	input wire logic [7:0]                       station_address_o,
	input wire logic                             setup_mode_o,
	input wire front_panel_pkg::display_type     display_o,
	input wire front_panel_pkg::port_config_type port_config_o,
	input wire logic                             nv_write_o,
	input wire logic                             erase_app_o
);
	logic [3:0] up_cnt;
	// ==========================================================
	// cycles since reset release, saturating
	always_ff @(posedge mclk_i)
		if (!reset_n_i)
			up_cnt <= 4'h0;
		else if (up_cnt != 4'hF)
			up_cnt <= up_cnt + 4'h1;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// ==========================================================
	// checks
	chk_address_follows: assert property (
		(up_cnt > 4'h5 && $stable(address_switch_i)) [*4] |-> station_address_o == address_switch_i)
		else $error("station address differs from switches");
	chk_one_wait: assert property (
		$rose(avs_req_i.read || avs_req_i.write) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("bus access not answered after one wait");
	chk_run_quiet: assert property (
		up_cnt == 4'hF && !setup_mode_o |->
		display_o.screen == front_panel_pkg::SCR_RUN && !nv_write_o && !erase_app_o)
		else $error("menu active outside setup");
	chk_store_mode: assert property (
		nv_write_o |=> !nv_write_o && display_o.screen == front_panel_pkg::SCR_MODE)
		else $error("store not followed by mode screen");
	chk_settings_fixed: assert property (
		up_cnt == 4'hF |-> $stable(port_config_o) && $stable(setup_mode_o))
		else $error("port settings changed before reboot");
	chk_one_shared: assert property (
		!(port_config_o.port2_slave && port_config_o.port3_slave))
		else $error("second and third port both slave");
	chk_shared_opens: assert property (
		display_o.screen == front_panel_pkg::SCR_SHARED
		&& $past(display_o.screen) == front_panel_pkg::SCR_SELECT
		|-> display_o.value == front_panel_pkg::SHARED_RESET)
		else $error("shared screen opened at wrong entry");
	chk_erase_clears: assert property (
		erase_app_o |=> !erase_app_o && display_o.screen == front_panel_pkg::SCR_CLEARED)
		else $error("erase not followed by cleared screen");
endmodule
bind front_panel_setup_menu front_panel_setup_menu_assertions #(.MSG_CYCLES(MSG_CYCLES)) u_chk (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .address_switch_i(address_switch_i),
	.avs_req_i(avs_req_i), .avs_waitrequest_o(avs_waitrequest_o),
	.station_address_o(station_address_o), .setup_mode_o(setup_mode_o),
	.display_o(display_o), .port_config_o(port_config_o), .nv_write_o(nv_write_o),
	.erase_app_o(erase_app_o)
);

// >>> operator_panel.sv
// operator model: presses the front-panel keys, promptly or slowly
`timescale 1ns/1ps
module operator_panel (
	input  wire logic mclk_i,
	output logic      key_up_o,
	output logic      key_down_o,
	output logic      key_ok_o
);
	initial
		{key_up_o, key_down_o, key_ok_o} = 3'h0;
	// setup chord held while power is applied
	task automatic hold_first_two(input logic on);
		key_up_o <= on;
		key_down_o <= on;
	endtask
	// key k (0 up, 1 down, 2 ok) pressed n times, each held for hold cycles
	task automatic press(input int k, input int n, input int hold);
		repeat (n)
		begin
			key_up_o <= (k == 0);
			key_down_o <= (k == 1);
			key_ok_o <= (k == 2);
			repeat (hold) @(posedge mclk_i);
			{key_up_o, key_down_o, key_ok_o} <= 3'h0;
			repeat (6) @(posedge mclk_i);
		end
	endtask
endmodule

// >>> front_panel_setup_menu_tb.sv
// self-checking bench: random operator sessions on the setup menu
`timescale 1ns/1ps
module front_panel_setup_menu_tb;
	logic                             mclk_i;
	logic                             reset_n_i;
	logic [7:0]                       switches;
	logic                             nv_valid;
	front_panel_pkg::nv_settings_type nv_in;
	front_panel_pkg::nv_settings_type saved;
	front_panel_pkg::avalon_req_type  req;
	logic [31:0]                      rdata;
	logic                             wait_req;
	logic [7:0]                       station;
	logic                             setup;
	front_panel_pkg::display_type     disp;
	front_panel_pkg::port_config_type cfg;
	front_panel_pkg::nv_settings_type nv_out;
	logic                             nv_wr;
	logic                             erase;
	logic                             k_up;
	logic                             k_dn;
	logic                             k_ok;
	logic [4:0]                       mode_seen;
	logic [31:0]                      word;
	logic [3:0]                       code;
	int                               miscompares;
	int                               tests_run;
	int                               cycles;
	int                               writes;
	int                               erases;
	int                               item;
	int                               val;
	int                               k;
	int                               n;

	front_panel_setup_menu #(.MSG_CYCLES(8)) dut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .address_switch_i(switches),
		.key_up_i(k_up), .step_down_key_i(k_dn), .key_ok_i(k_ok), .nv_valid_i(nv_valid),
		.nv_data_i(nv_in), .avs_req_i(req), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_req), .station_address_o(station), .setup_mode_o(setup),
		.display_o(disp), .port_config_o(cfg), .nv_data_o(nv_out), .nv_write_o(nv_wr),
		.erase_app_o(erase)
	);
	operator_panel op (.mclk_i(mclk_i), .key_up_o(k_up), .key_down_o(k_dn), .key_ok_o(k_ok));

	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// ==========================================================
	// pulse counters, mode screen capture and hang limit
	always @(posedge mclk_i)
	begin
		cycles <= cycles + 1;
		if (nv_wr === 1'b1)
			writes <= writes + 1;
		if (erase === 1'b1)
			erases <= erases + 1;
		if (disp.screen === front_panel_pkg::SCR_MODE)
			mode_seen <= disp.value;
		if (cycles == 40000)
		begin
			miscompares = miscompares + 1;
			report_and_stop();
		end
	end
	// ==========================================================
	// expectations and helpers
	function automatic logic [31:0] scr(input front_panel_pkg::screen_type s, input int v);
		return 32'({s, 5'(v)});
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d,
		output logic [31:0] q);
		req <= '{address: a, read: ~wr, write: wr, writedata: d};
		// only the bench's cycle ceiling ends a wait that never answers
		do
			@(posedge mclk_i);
		while (wait_req !== 1'b0);
		q = rdata;
		req <= '0;
		@(posedge mclk_i);
	endtask
	task automatic boot(input logic keys, input logic valid, input logic [8:0] s);
		@(posedge mclk_i);
		reset_n_i <= 1'b0;
		nv_valid <= valid;
		nv_in <= s;
		op.hold_first_two(keys);
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (10) @(posedge mclk_i);
		op.hold_first_two(1'b0);
		repeat (6) @(posedge mclk_i);
	endtask
	task automatic key(input int kk, input int times);
		op.press(kk, times, $urandom_range(8, 4));
	endtask
	task automatic goto_item(input int t);
		while (item != t)
		begin
			key(1, 1);
			item = (item + 1) % 3;
		end
	endtask
	task automatic commit(input logic [8:0] exp_nv, input logic [4:0] exp_mode);
		int w;
		w = writes;
		mode_seen = 5'h1F;
		key(2, 1);
		repeat (20) @(posedge mclk_i);
		check("stores", 32'(w + 1), 32'(writes));
		check("stored", 32'(exp_nv), 32'(nv_out));
		if (exp_mode != 5'h1F)
			check("mode", 32'(exp_mode), 32'(mode_seen));
		check("back", scr(front_panel_pkg::SCR_SELECT, item), 32'(disp));
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		reset_n_i = 1'b0;
		nv_valid = 1'b0;
		nv_in = '0;
		req = '0;
		void'($urandom(32'h0A5A));
		switches <= 8'($urandom_range(255, 1));
		boot(1'b1, 1'b0, 9'h000);
		check("station", 32'(switches), 32'(station));
		check("setup", 32'h1, 32'(setup));
		check("screen", scr(front_panel_pkg::SCR_SELECT, 1), 32'(disp));
		check("ports", 32'({4'h4, 2'b10, 4'h4}), 32'(cfg));
		bus(4'h0, 1'b1, 32'hFFFF_FFFF, word);
		bus(4'h0, 1'b0, 32'h0, word);
		check("status", 32'h0001_1100 | 32'(switches), word);
		bus(4'hC, 1'b0, 32'h0, word);
		check("unmapped", 32'h0, word);
		val = $urandom_range(12, 6);
		bus(4'h8, 1'b1, 32'(val), word);
		bus(4'h8, 1'b0, 32'h0, word);
		check("hold", 32'(val), word);
		$display("test registers done");
		item = 1;
		repeat (6)
		begin
			k = $urandom_range(1, 0);
			key(k, 1);
			item = (item + (k == 1 ? 1 : 2)) % 3;
			check("item", scr(front_panel_pkg::SCR_SELECT, item), 32'(disp));
		end
		goto_item(0);
		key(2, 1);
		val = 4;
		check("rate open", scr(front_panel_pkg::SCR_RATE1, 4), 32'(disp));
		repeat (8)
		begin
			k = $urandom_range(1, 0);
			key(k, 1);
			val = (val + (k == 0 ? 1 : 9)) % 10;
			check("rate", scr(front_panel_pkg::SCR_RATE1, val), 32'(disp));
		end
		code = 4'(val);
		commit({code, front_panel_pkg::SHARED_RESET}, front_panel_pkg::MODE_RS232);
		$display("test first port done");
		for (int r = 0; r < 3; r++)
		begin
			goto_item(1);
			key(2, 1);
			check("shared open", scr(front_panel_pkg::SCR_SHARED, 5), 32'(disp));
			// third port, then second port by up, then down past the end to the dash
			k = (r == 1) ? 0 : 1;
			n = (r == 0) ? 6 : ((r == 1) ? $urandom_range(4, 1) : 16);
			key(k, n);
			val = (k == 1) ? (5 + n) % 21 : 5 - n;
			check("shared", scr(front_panel_pkg::SCR_SHARED, val), 32'(disp));
			commit({code, 5'(val)}, (val == 0) ? 5'h1F : ((val < 11) ?
				front_panel_pkg::MODE_RS485 : front_panel_pkg::MODE_RS232_485));
			if (r == 0)
				saved = nv_out;
		end
		$display("test shared screen done");
		boot(1'b1, 1'b1, saved);
		check("third slave", 32'({code, 2'b01, 4'h0}), 32'(cfg));
		boot(1'b1, 1'b1, {code, 5'h00});
		check("dash", 32'h0, 32'({cfg.port2_slave, cfg.port3_slave}));
		$display("test reboot done");
		item = 1;
		goto_item(2);
		key(2, 1);
		check("erase open", scr(front_panel_pkg::SCR_ERASE, 0), 32'(disp));
		key(0, 1);
		check("erase yes", scr(front_panel_pkg::SCR_ERASE, 1), 32'(disp));
		key(1, 1);
		check("erase no", scr(front_panel_pkg::SCR_ERASE, 0), 32'(disp));
		key(2, 1);
		check("kept", 32'h0, 32'(erases));
		check("after no", scr(front_panel_pkg::SCR_SELECT, 2), 32'(disp));
		key(2, 1);
		key(1, 1);
		key(2, 2);
		check("erased", 32'h1, 32'(erases));
		check("cleared", 32'(front_panel_pkg::SCR_CLEARED), 32'(disp.screen));
		$display("test erase done");
		switches <= front_panel_pkg::ADDRESS_RESET;
		boot(1'b0, 1'b1, saved);
		check("normal", 32'h0, 32'(setup));
		check("delivered", 32'h01, 32'(station));
		key(2, 1);
		check("run", 32'(front_panel_pkg::SCR_RUN), 32'(disp.screen));
		$display("test normal boot done");
		report_and_stop();
	end
endmodule
